// ===== rtl/cmc_pkg.sv
// Constants for the master configuration clock generator.
// Assumes one 50 MHz system clock; the oscillator is modelled by a phase accumulator.
package cmc_pkg;

  localparam int SYS_CLK_KHZ = 50000;
  // Model runs slower than nominal so the 62 MHz setting stays below half the system clock
  localparam int OSC_SCALE = 8;
  localparam int ACC_W = 32;
  localparam int SEL_W = 3;
  localparam int NUM_FREQ = 6;
  localparam logic [SEL_W-1:0] SEL_DEFAULT = 3'h0;

  // Nominal frequencies in kHz, indexed by selection code
  localparam int FREQ_KHZ [NUM_FREQ] = '{2400, 4800, 9700, 19400, 38800, 62000};

  // Longest half period of the slowest setting, in system cycles, with margin
  localparam int HALF_MAX_CYC = (SYS_CLK_KHZ * OSC_SCALE) / (2 * FREQ_KHZ[0]) + 2;

  typedef enum logic [2:0] {
    ST_DEFAULT = 3'b001,
    ST_PENDING = 3'b010,
    ST_CHOSEN  = 3'b100
  } cmc_state_t;

  function automatic logic [ACC_W-1:0] cmc_inc(input logic [SEL_W-1:0] sel);
    logic [63:0] num;
    num = 64'(FREQ_KHZ[sel]) << ACC_W;
    return ACC_W'(num / 64'(SYS_CLK_KHZ * OSC_SCALE));
  endfunction

  function automatic logic cmc_sel_ok(input logic [SEL_W-1:0] sel);
    return 32'(sel) < NUM_FREQ;
  endfunction

endpackage

// ===== rtl/cmc_sync2.sv
// Two flip-flop level synchroniser.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ns
`default_nettype none
module cmc_sync2 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Level in and out
  input wire logic i_d,
  output logic o_q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = i_rstn ? i_d : 1'b0;
    next_q = i_rstn ? meta : 1'b0;
  end

  always_ff @(posedge i_clk) begin
    meta <= next_meta;
    o_q <= next_q;
  end
endmodule
`default_nettype wire

// ===== rtl/cmc_master_clock.sv
// Master configuration clock generator with selectable frequency.
// Assumes the bitstream loader shares I_MCLK; configuration-done arrives asynchronously.
`timescale 1ns/1ns
`default_nettype none
module cmc_master_clock
  import cmc_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  // Clock-select bits from the bitstream loader
  input wire logic I_SEL_VALID,
  input wire logic [SEL_W-1:0] I_SEL_CODE,
  // Configuration status
  input wire logic I_CFG_DONE,
  // Clock outputs
  output logic O_CFG_CLK,
  output logic O_USER_CLK,
  // Status
  output logic [SEL_W-1:0] O_FREQ_SEL,
  output logic O_SEL_PENDING,
  output logic O_SEL_ERR
);

  ////////////////////////////////////////////////////////////////////////////
  logic cfg_done;

  cmc_sync2 u_done_sync (
    .i_clk(I_MCLK),
    .i_rstn(I_RSTN),
    .i_d(I_CFG_DONE),
    .o_q(cfg_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  cmc_state_t state;
  cmc_state_t next_state;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] next_inc;
  logic [SEL_W-1:0] cur_sel;
  logic [SEL_W-1:0] next_cur_sel;
  logic [SEL_W-1:0] req_sel;
  logic [SEL_W-1:0] next_req_sel;
  logic user_en;
  logic next_user_en;
  logic next_cfg_clk;
  logic next_user_clk;
  logic next_sel_err;
  logic wrap;
  logic [ACC_W:0] sum;

  always_comb begin
    sum = {1'b0, acc} + {1'b0, inc};
    wrap = sum[ACC_W];
    next_state = state;
    next_req_sel = req_sel;
    next_cur_sel = cur_sel;
    next_inc = inc;
    next_user_en = user_en;
    next_sel_err = O_SEL_ERR;
    // Accumulator free-runs in every state so the clock never stops
    next_acc = sum[ACC_W-1:0];
    case (state)
      ST_DEFAULT, ST_CHOSEN: begin
        if (I_SEL_VALID) begin
          if (cmc_sel_ok(I_SEL_CODE)) begin
            next_req_sel = I_SEL_CODE;
            next_state = ST_PENDING;
          end else begin
            next_sel_err = 1'b1;
          end
        end
      end
      ST_PENDING: begin
        // Switch only at the falling edge so the old high phase completes intact
        if (wrap) begin
          next_cur_sel = req_sel;
          next_inc = cmc_inc(req_sel);
          next_state = ST_CHOSEN;
        end
      end
      default: next_state = ST_DEFAULT;
    endcase
    // Gate changes only while the clock goes low, so no partial user pulse
    if (wrap) begin
      next_user_en = cfg_done;
    end
    next_cfg_clk = next_acc[ACC_W-1];
    next_user_clk = next_acc[ACC_W-1] & next_user_en;
    if (!I_RSTN) begin
      next_state = ST_DEFAULT;
      next_acc = '0;
      next_inc = cmc_inc(SEL_DEFAULT);
      next_cur_sel = SEL_DEFAULT;
      next_req_sel = SEL_DEFAULT;
      next_user_en = 1'b0;
      next_cfg_clk = 1'b0;
      next_user_clk = 1'b0;
      next_sel_err = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    state <= next_state;
    acc <= next_acc;
    inc <= next_inc;
    cur_sel <= next_cur_sel;
    req_sel <= next_req_sel;
    user_en <= next_user_en;
    O_CFG_CLK <= next_cfg_clk;
    O_USER_CLK <= next_user_clk;
    O_SEL_ERR <= next_sel_err;
  end

  assign O_FREQ_SEL = cur_sel;
  assign O_SEL_PENDING = (state == ST_PENDING);

  ////////////////////////////////////////////////////////////////////////////
  // Helper: cycles since the master clock last changed level
  logic [15:0] still_cnt;
  logic [15:0] next_still_cnt;
  logic sel_seen;
  logic next_sel_seen;
  localparam int HALF_MAX = HALF_MAX_CYC;

  always_comb begin
    next_still_cnt = (O_CFG_CLK != next_cfg_clk) ? 16'h0000 : still_cnt + 16'h0001;
    next_sel_seen = sel_seen | (I_SEL_VALID & cmc_sel_ok(I_SEL_CODE));
    if (!I_RSTN) begin
      next_still_cnt = 16'h0000;
      next_sel_seen = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    still_cnt <= next_still_cnt;
    sel_seen <= next_sel_seen;
  end

  property p_default_after_reset;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    !sel_seen |-> (cur_sel == SEL_DEFAULT && inc == cmc_inc(SEL_DEFAULT));
  endproperty
  a_default_after_reset: assert property (p_default_after_reset)
    else $error("Clock left default before any selection");

  property p_fixed_set;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    cmc_sel_ok(cur_sel) && inc == cmc_inc(cur_sel);
  endproperty
  a_fixed_set: assert property (p_fixed_set)
    else $error("Clock rate outside the fixed set");

  property p_switch_on_select;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $changed(inc) |-> $past(state == ST_PENDING) && $past(wrap) && cur_sel == $past(req_sel);
  endproperty
  a_switch_on_select: assert property (p_switch_on_select)
    else $error("Rate changed without a received selection");

  property p_bad_code_ignored;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    (I_SEL_VALID && !cmc_sel_ok(I_SEL_CODE) && state != ST_PENDING)
      |=> O_SEL_ERR && !O_SEL_PENDING && $stable(cur_sel);
  endproperty
  a_bad_code_ignored: assert property (p_bad_code_ignored)
    else $error("Invalid code altered the clock");

  property p_never_stops;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    still_cnt < 16'(HALF_MAX);
  endproperty
  a_never_stops: assert property (p_never_stops)
    else $error("Master clock stalled");

  property p_user_gated;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    // Enable is latched at the falling edge, so done may already have dropped here
    $rose(O_USER_CLK) |-> user_en && $rose(O_CFG_CLK);
  endproperty
  a_user_gated: assert property (p_user_gated)
    else $error("User clock pulsed before configuration done");

  property p_no_runt_high;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $rose(O_CFG_CLK) |-> O_CFG_CLK [*3];
  endproperty
  a_no_runt_high: assert property (p_no_runt_high)
    else $error("Runt high pulse on master clock");

  property p_no_runt_low;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $fell(O_CFG_CLK) |-> !O_CFG_CLK [*3];
  endproperty
  a_no_runt_low: assert property (p_no_runt_low)
    else $error("Runt low pulse on master clock");

  property p_switch_done;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $rose(state == ST_CHOSEN);
  endproperty
  c_switch_done: cover property (p_switch_done);

  property p_user_running;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $rose(O_USER_CLK);
  endproperty
  c_user_running: cover property (p_user_running);

  property p_fastest;
    @(posedge I_MCLK) disable iff (!I_RSTN)
    cur_sel == SEL_W'(NUM_FREQ - 1) && $rose(O_CFG_CLK);
  endproperty
  c_fastest: cover property (p_fastest);

endmodule
`default_nettype wire

// ===== verification/cmc_loader.sv
// Partner model: the bitstream loader that offers clock-select bits.
// Assumes it shares the system clock with the block and drives just after the rising edge.
`timescale 1ns/1ns
`default_nettype none
module cmc_loader
  import cmc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Clock-select offer
  output logic o_sel_valid,
  output logic [SEL_W-1:0] o_sel_code
);
  initial begin
    o_sel_valid = 1'b0;
    o_sel_code = 3'h7;
  end
  // One-cycle pulse; code inverted when idle so stale bits are never trusted
  task automatic send(input logic [SEL_W-1:0] code);
    @(posedge i_clk);
    #1;
    o_sel_valid = 1'b1;
    o_sel_code = code;
    @(posedge i_clk);
    #1;
    o_sel_valid = 1'b0;
    o_sel_code = ~code;
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the master configuration clock generator.
// Assumes the loader model drives selections; the bench drives reset and done.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cmc_pkg::*;
  logic clk, rstn, done, sv, cfg_clk, user_clk, pend, err;
  logic [SEL_W-1:0] code, fsel;
  int n_fail = 0;
  int comparisons = 0;
  logic cfg_clk_d;
  always @(posedge clk) cfg_clk_d <= cfg_clk;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  cmc_loader cmc_loader_inst (.i_clk(clk), .o_sel_valid(sv), .o_sel_code(code));
  cmc_master_clock cmc_master_clock_inst (
    .I_MCLK(clk), .I_RSTN(rstn), .I_SEL_VALID(sv), .I_SEL_CODE(code),
    .I_CFG_DONE(done), .O_CFG_CLK(cfg_clk), .O_USER_CLK(user_clk),
    .O_FREQ_SEL(fsel), .O_SEL_PENDING(pend), .O_SEL_ERR(err));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One system cycle of period jitter is inherent
  task automatic chk_per(input int i);
    time t0;
    int p, e;
    e = SYS_CLK_KHZ * OSC_SCALE / FREQ_KHZ[i];
    @(posedge cfg_clk);
    t0 = $time;
    @(posedge cfg_clk);
    p = int'(($time - t0) / 20);
    chk(32'((p >= e - 1 && p <= e + 1) ? e : p), 32'(e));
  endtask
  task automatic wait_applied();
    // Sample off the edge so the registered status has settled
    for (int k = 0; k < 400 && pend !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_default();
    chk(32'(fsel), 32'h0000_0000);
    chk_per(0);
    for (int k = 0; k < 2000; k++) begin
      @(posedge clk);
      #1;
      if (k % 500 == 0) chk(32'({fsel, user_clk}), 32'h0000_0000);
    end
    $display("test default done");
  endtask
  task automatic t_select();
    logic [SEL_W-1:0] prev;
    for (int i = 5; i >= 0; i--) begin
      prev = fsel;
      cmc_loader_inst.send(SEL_W'(i));
      chk(32'({pend, fsel}), 32'({1'b1, prev}));
      wait_applied();
      chk(32'({pend, fsel}), 32'(i));
      chk_per(i);
    end
    $display("test select done");
  endtask
  task automatic t_invalid();
    logic [SEL_W-1:0] prev;
    prev = fsel;
    for (int c = 6; c < 8; c++) begin
      cmc_loader_inst.send(SEL_W'(c));
      repeat (200) @(posedge clk);
      #1;
      chk(32'({err, pend, fsel}), 32'({2'b10, prev}));
    end
    $display("test invalid done");
  endtask
  task automatic t_user();
    int toggles;
    toggles = 0;
    cmc_loader_inst.send(3'h4);
    wait_applied();
    done = 1'b1;
    repeat (60) @(posedge clk);
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      #1;
      if (cfg_clk !== user_clk) chk(32'(user_clk), 32'(cfg_clk));
      if (cfg_clk !== cfg_clk_d) toggles++;
    end
    chk(32'(toggles > 40), 32'h0000_0001);
    chk(32'(user_clk === cfg_clk), 32'h0000_0001);
    $display("test user done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    done = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_default();
    t_select();
    t_invalid();
    t_user();
    wrap_up();
  end
  initial begin
    #(20 * 60000);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
